// file: hwu_pkg.sv
// Purpose: Shared constants, types and helpers for the host-link serial port with wake lines
// Assumes: One 100 MHz core clock; asynchronous active-high core reset
// Notes: Bit periods are whole clock counts; rounding error stays well inside the link tolerance
package hwu_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_MIN = 115_200;
  localparam int BAUD_MAX = 3_000_000;
  localparam int BAUD_DEFAULT = 115_200;
  localparam int BAUD_COMMON_A = 921_600;
  localparam int BAUD_COMMON_B = 1_500_000;
  localparam int DIV_W = 16;
  // Clock counts per bit, rounded to nearest
  localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'((CLK_HZ + BAUD_MAX / 2) / BAUD_MAX);
  localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'((CLK_HZ + BAUD_MIN / 2) / BAUD_MIN);
  localparam logic [DIV_W-1:0] DIV_DEFAULT = DIV_W'((CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT);
  localparam logic [DIV_W-1:0] DIV_COMMON_A = DIV_W'((CLK_HZ + BAUD_COMMON_A / 2) / BAUD_COMMON_A);
  localparam logic [DIV_W-1:0] DIV_COMMON_B = DIV_W'((CLK_HZ + BAUD_COMMON_B / 2) / BAUD_COMMON_B);
  localparam int DATA_BITS = 8;
  localparam int HCI_FIFO_DEPTH = 1040;
  localparam int PERIPH_FIFO_DEPTH = 256;
  localparam int RTS_MARGIN = 16;
  localparam logic [7:0] H4_TYPE_FIRST = 8'h01;
  localparam logic [7:0] H4_TYPE_LAST = 8'h05;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [1:0] {
    HWU_IDLE = 2'b00,
    HWU_START = 2'b01,
    HWU_DATA = 2'b10,
    HWU_STOP = 2'b11
  } hwu_phase_t;

  // Keeps any requested divisor inside the supported rate span
  function automatic logic [DIV_W-1:0] hwu_clamp_div(input logic [DIV_W-1:0] d);
    logic [DIV_W-1:0] r;
    r = d;
    if (d < DIV_MIN)
    begin
      r = DIV_MIN;
    end
    else if (d > DIV_MAX)
    begin
      r = DIV_MAX;
    end
    return r;
  endfunction
endpackage

// file: hwu_fifo.sv
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: Single clock; depth need not be a power of two
// Notes: Full and empty are held as flops so the handshake outputs are clean
`timescale 1ns/1ps
module hwu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  import hwu_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] cnt;
    logic not_full;
    logic not_empty;
  } hwu_fifo_st_t;

  hwu_fifo_st_t s;
  hwu_fifo_st_t next_s;
  logic push;
  logic pop;

  assign push = in_valid && s.not_full;
  assign pop = out_ready && s.not_empty;
  assign in_ready = s.not_full;
  assign out_valid = s.not_empty;
  assign out_data = s.mem[s.rptr];
  assign count = s.cnt;

  // Pointers wrap at DEPTH-1 since depth may be odd sized
  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wptr] = in_data;
      next_s.wptr = (s.wptr == AW'(DEPTH - 1)) ? '0 : s.wptr + 1'b1;
    end
    if (pop)
    begin
      next_s.rptr = (s.rptr == AW'(DEPTH - 1)) ? '0 : s.rptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_s.cnt = s.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      next_s.cnt = s.cnt - 1'b1;
    end
    next_s.not_full = next_s.cnt != CW'(DEPTH);
    next_s.not_empty = next_s.cnt != '0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.not_full <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (rst)
    (s.cnt == CW'(DEPTH)) |-> (!in_ready && (count <= CW'(DEPTH))))
    else $error("fifo full but still accepting");
  fifo_count_a: assert property (@(posedge clk) disable iff (rst)
    (in_valid && in_ready && !(out_valid && out_ready)) |=> (count == $past(count) + 1'b1))
    else $error("fifo count did not follow a push");
endmodule

// file: hwu_bit_timer.sv
// Purpose: Bit period counter giving mid-bit and end-of-bit enable pulses
// Assumes: Divisor is held steady while run is high
// Notes: Counter rests at zero when idle so each character starts a fresh period
`timescale 1ns/1ps
module hwu_bit_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [hwu_pkg::DIV_W-1:0] div,
  output logic half_tick,
  output logic full_tick
);
  import hwu_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
  } hwu_timer_st_t;

  hwu_timer_st_t s;
  hwu_timer_st_t next_s;

  assign full_tick = run && (s.cnt == div - 1'b1);
  assign half_tick = run && (s.cnt == (div >> 1));

  // Period restarts on each end-of-bit pulse
  always_comb
  begin
    next_s = s;
    if (!run || full_tick)
    begin
      next_s.cnt = '0;
    end
    else
    begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  tick_spacing_a: assert property (@(posedge clk) disable iff (rst)
    (full_tick && run) |=> !full_tick)
    else $error("bit period shorter than two clocks");
endmodule

// file: hwu_port.sv
// Purpose: Host-link serial port with RTS/CTS flow control, H4 indicator check and wake lines
// Assumes: Pin selects and wake controls are static configuration from the command processor
// Notes: Same module serves the peripheral port with FIFO_DEPTH set to the smaller size
`timescale 1ns/1ps
module hwu_port #(
  parameter int FIFO_DEPTH = hwu_pkg::HCI_FIFO_DEPTH,
  parameter int N_GPIO = 8,
  parameter int SEL_W = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [N_GPIO-1:0] gpio_in,
  output logic [N_GPIO-1:0] gpio_out,
  output logic [N_GPIO-1:0] gpio_oe,
  input wire logic [SEL_W-1:0] rx_pin_sel,
  input wire logic [SEL_W-1:0] cts_pin_sel,
  input wire logic [SEL_W-1:0] tx_pin_sel,
  input wire logic [SEL_W-1:0] rts_pin_sel,
  input wire logic [hwu_pkg::DIV_W-1:0] baud_div,
  input wire logic baud_load,
  output logic [hwu_pkg::DIV_W-1:0] baud_div_now,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  input wire logic rx_sop,
  output logic rx_frame_err,
  output logic rx_overrun,
  output logic h4_type_err,
  input wire logic wake_enable,
  input wire logic wake_polarity,
  input wire logic device_wake_request,
  output logic device_awake,
  input wire logic host_wake_request,
  input wire logic host_wake_polarity,
  output logic host_wake
);
  import hwu_pkg::*;
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [CW-1:0] RTS_LEVEL = CW'(FIFO_DEPTH - RTS_MARGIN);

  typedef struct packed {
    logic [N_GPIO-1:0] pin_meta;
    logic [N_GPIO-1:0] pin_sync;
    logic wake_meta;
    logic wake_sync;
    logic [DIV_W-1:0] div;
    logic loaded;
    hwu_phase_t tx_phase;
    logic [7:0] tx_shift;
    logic [2:0] tx_bit;
    logic tx_line;
    logic [DIV_W-1:0] tx_div;
    hwu_phase_t rx_phase;
    logic [7:0] rx_shift;
    logic [2:0] rx_bit;
    logic rx_prev;
    logic [DIV_W-1:0] rx_div;
    logic rx_push;
    logic rts_n;
    logic [N_GPIO-1:0] gpio_out;
    logic [N_GPIO-1:0] gpio_oe;
    logic dev_awake;
    logic host_wake;
    logic frame_err;
    logic overrun;
    logic type_err;
  } hwu_port_st_t;

  hwu_port_st_t s;
  hwu_port_st_t next_s;
  logic rx_now;
  logic cts_n_now;
  logic tx_out_valid;
  logic tx_out_ready;
  logic [7:0] tx_out_data;
  logic rx_in_ready;
  logic [CW-1:0] rx_count;
  logic tx_half;
  logic tx_full;
  logic rx_half;
  logic rx_full;
  logic h4_bad;

  // Link pins are read only after the two-flop synchroniser
  assign rx_now = s.pin_sync[rx_pin_sel];
  assign cts_n_now = s.pin_sync[cts_pin_sel];
  // A new byte leaves only while CTS is asserted low
  assign tx_out_ready = (s.tx_phase == HWU_IDLE) && !cts_n_now;
  assign h4_bad = (rx_data < H4_TYPE_FIRST) || (rx_data > H4_TYPE_LAST);

  // Separate byte buffers per direction; depth set per port
  hwu_fifo #(
    .WIDTH(DATA_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(tx_out_valid),
    .out_ready(tx_out_ready),
    .out_data(tx_out_data),
    .count()
  );

  hwu_fifo #(
    .WIDTH(DATA_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(s.rx_push),
    .in_ready(rx_in_ready),
    .in_data(s.rx_shift),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data),
    .count(rx_count)
  );

  // Each direction times its own character with the divisor latched at its start
  hwu_bit_timer u_tx_timer (
    .clk(clk),
    .rst(rst),
    .run(s.tx_phase != HWU_IDLE),
    .div(s.tx_div),
    .half_tick(tx_half),
    .full_tick(tx_full)
  );

  hwu_bit_timer u_rx_timer (
    .clk(clk),
    .rst(rst),
    .run(s.rx_phase != HWU_IDLE),
    .div(s.rx_div),
    .half_tick(rx_half),
    .full_tick(rx_full)
  );

  // Next state of synchronisers, baud setting, both serialisers, flow and wake lines
  always_comb
  begin
    next_s = s;
    next_s.pin_meta = gpio_in;
    next_s.pin_sync = s.pin_meta;
    next_s.wake_meta = device_wake_request;
    next_s.wake_sync = s.wake_meta;
    next_s.rx_prev = rx_now;
    next_s.rx_push = 1'b0;
    next_s.frame_err = 1'b0;
    next_s.overrun = 1'b0;
    next_s.type_err = 1'b0;

    // Rate change lands between characters since each one latches its own divisor
    if (baud_load)
    begin
      next_s.div = hwu_clamp_div(baud_div);
      next_s.loaded = 1'b1;
    end

    // Transmit: start bit, eight data bits LSB first, stop bit
    case (s.tx_phase)
      HWU_IDLE:
      begin
        next_s.tx_line = 1'b1;
        if (tx_out_valid && tx_out_ready)
        begin
          next_s.tx_shift = tx_out_data;
          next_s.tx_div = s.div;
          next_s.tx_line = 1'b0;
          next_s.tx_phase = HWU_START;
        end
      end
      HWU_START:
      begin
        if (tx_full)
        begin
          next_s.tx_line = s.tx_shift[0];
          next_s.tx_shift = s.tx_shift >> 1;
          next_s.tx_bit = '0;
          next_s.tx_phase = HWU_DATA;
        end
      end
      HWU_DATA:
      begin
        if (tx_full)
        begin
          if (s.tx_bit == LAST_BIT)
          begin
            next_s.tx_line = 1'b1;
            next_s.tx_phase = HWU_STOP;
          end
          else
          begin
            next_s.tx_line = s.tx_shift[0];
            next_s.tx_shift = s.tx_shift >> 1;
            next_s.tx_bit = s.tx_bit + 1'b1;
          end
        end
      end
      HWU_STOP:
      begin
        if (tx_full)
        begin
          next_s.tx_phase = HWU_IDLE;
        end
      end
      default:
      begin
        next_s.tx_phase = HWU_IDLE;
      end
    endcase

    // Receive: sample at mid-bit, which leaves almost half a bit of slack for rate error
    case (s.rx_phase)
      HWU_IDLE:
      begin
        if (s.rx_prev && !rx_now)
        begin
          next_s.rx_div = s.div;
          next_s.rx_phase = HWU_START;
        end
      end
      HWU_START:
      begin
        if (rx_half)
        begin
          // A start bit gone high by mid-bit was only a glitch
          next_s.rx_phase = rx_now ? HWU_IDLE : HWU_DATA;
          next_s.rx_bit = '0;
        end
      end
      HWU_DATA:
      begin
        if (rx_half)
        begin
          next_s.rx_shift = {rx_now, s.rx_shift[7:1]};
          if (s.rx_bit == LAST_BIT)
          begin
            next_s.rx_phase = HWU_STOP;
          end
          else
          begin
            next_s.rx_bit = s.rx_bit + 1'b1;
          end
        end
      end
      HWU_STOP:
      begin
        if (rx_half)
        begin
          // Leaving at mid stop bit keeps back-to-back start edges visible
          next_s.rx_phase = HWU_IDLE;
          next_s.rx_push = rx_now;
          next_s.frame_err = !rx_now;
        end
      end
      default:
      begin
        next_s.rx_phase = HWU_IDLE;
      end
    endcase

    // A byte that meets a full buffer is dropped and flagged
    next_s.overrun = s.rx_push && !rx_in_ready;

    // Packet-start bytes must carry a known H4 indicator
    next_s.type_err = rx_valid && rx_ready && rx_sop && h4_bad;

    // RTS goes high while the buffer has no more than the margin free
    next_s.rts_n = rx_count >= RTS_LEVEL;

    // Route the two outputs onto their chosen pins
    for (int i = 0; i < N_GPIO; i++)
    begin
      next_s.gpio_out[i] = 1'b0;
      next_s.gpio_oe[i] = 1'b0;
      if (SEL_W'(i) == tx_pin_sel)
      begin
        next_s.gpio_out[i] = next_s.tx_line;
        next_s.gpio_oe[i] = 1'b1;
      end
      else if (SEL_W'(i) == rts_pin_sel)
      begin
        next_s.gpio_out[i] = next_s.rts_n;
        next_s.gpio_oe[i] = 1'b1;
      end
    end

    // Wake lines do nothing until enabled by command
    next_s.dev_awake = wake_enable && (s.wake_sync == wake_polarity);
    if (wake_enable && (host_wake_request || tx_out_valid))
    begin
      next_s.host_wake = host_wake_polarity;
    end
    else
    begin
      next_s.host_wake = !host_wake_polarity;
    end
  end

  // Reset leaves the port idle at the default rate with RTS deasserted
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.pin_meta <= '1;
      s.pin_sync <= '1;
      s.div <= DIV_DEFAULT;
      s.tx_line <= 1'b1;
      s.rx_prev <= 1'b1;
      s.rts_n <= 1'b1;
      s.host_wake <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign gpio_out = s.gpio_out;
  assign gpio_oe = s.gpio_oe;
  assign baud_div_now = s.div;
  assign rx_frame_err = s.frame_err;
  assign rx_overrun = s.overrun;
  assign h4_type_err = s.type_err;
  assign device_awake = s.dev_awake;
  assign host_wake = s.host_wake;

  default_rate_a: assert property (@(posedge clk) disable iff (rst)
    !s.loaded |-> (baud_div_now == DIV_DEFAULT))
    else $error("rate left default before any rate command");
  rate_range_a: assert property (@(posedge clk) disable iff (rst)
    (baud_div_now >= DIV_MIN) && (baud_div_now <= DIV_MAX))
    else $error("bit divisor outside supported span");
  rate_change_a: assert property (@(posedge clk) disable iff (rst)
    baud_load |=> (baud_div_now == hwu_clamp_div($past(baud_div))))
    else $error("rate command not applied next cycle");
  rts_near_full_a: assert property (@(posedge clk) disable iff (rst)
    (rx_count >= RTS_LEVEL) |=> s.rts_n)
    else $error("RTS asserted while receive buffer near full");
  cts_hold_a: assert property (@(posedge clk) disable iff (rst)
    ((s.tx_phase == HWU_IDLE) && cts_n_now) |=> (s.tx_phase == HWU_IDLE))
    else $error("byte started while CTS deasserted");
  start_bit_a: assert property (@(posedge clk) disable iff (rst)
    (tx_out_valid && tx_out_ready) |=> (!s.tx_line && (s.tx_phase == HWU_START)) [*2])
    else $error("start bit not low at character start");
  stop_bit_a: assert property (@(posedge clk) disable iff (rst)
    (s.tx_phase == HWU_STOP) |-> s.tx_line)
    else $error("stop bit not high");
  h4_check_a: assert property (@(posedge clk) disable iff (rst)
    (rx_valid && rx_ready && rx_sop && h4_bad) |=> h4_type_err)
    else $error("bad packet indicator not flagged");
  wake_gate_a: assert property (@(posedge clk) disable iff (rst)
    !wake_enable |=> (!device_awake && (host_wake == !$past(host_wake_polarity))))
    else $error("wake lines active while disabled");
  tx_route_a: assert property (@(posedge clk) disable iff (rst)
    $stable(tx_pin_sel) |=> gpio_oe[$past(tx_pin_sel)])
    else $error("transmit pin not driven");
endmodule

// file: hwu_host_model.sv
// Purpose: Host serial port model facing the device link
// Assumes: Idle line is high; bit period in clocks given per character
// Notes: Sender ignores RTS when the bench asks, to provoke overrun, or after 20000 clocks of waiting
`timescale 1ns/1ps
module hwu_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] div,
  input wire logic hold_off,
  input wire logic ignore_rts,
  input wire logic tx_pin,
  input wire logic rts_n,
  output logic rx_pin,
  output logic cts_n
);
  logic [8:0] got_q[$];
  logic [8:0] sh;
  logic seen_idle;

  // CTS high holds the device off, low lets it stream
  assign cts_n = hold_off;

  initial
  begin
    rx_pin = 1'b1;
    seen_idle = 1'b0;
  end

  // Mid-bit capture; a line seen high first guards against reset garbage
  always
  begin
    @(posedge clk);
    if (rst || tx_pin !== 1'b0)
    begin
      seen_idle = !rst && tx_pin === 1'b1;
    end
    else if (seen_idle)
    begin
      repeat (div / 2) @(posedge clk);
      for (int i = 0; i < 9; i++)
      begin
        repeat (div) @(posedge clk);
        sh[i] = tx_pin;
      end
      got_q.push_back(sh);
    end
  end

  // One character at the caller's period, either cur_div or a skewed value from the bench
  task automatic send(input logic [7:0] d, input int per, input logic stop);
    logic [9:0] fr;
    fr = {stop, d, 1'b0};
    for (int w = 0; w < 20000 && rts_n === 1'b1 && !ignore_rts; w++)
      @(posedge clk);
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      rx_pin <= fr[i];
      repeat (per - 1) @(posedge clk);
    end
    @(posedge clk);
    rx_pin <= 1'b1;
  endtask
endmodule

// file: hwu_port_tb_top.sv
// Purpose: Self-checking bench for the host-link serial port
// Assumes: Small FIFO depth so the flow threshold and overrun come quickly
// Notes: Random bytes from a 16-bit LFSR with a fixed start value
`timescale 1ns/1ps
module hwu_port_tb_top;
  import hwu_pkg::*;
  localparam int DEPTH = 24;
  localparam int RXP = 5;
  localparam int CTP = 6;
  localparam int TXP = 1;
  localparam int RTP = 4;
  logic clk, rst, baud_load, tx_valid, tx_ready, rx_valid, rx_ready, rx_sop;
  logic [7:0] gpio_in, gpio_out, gpio_oe, tx_data, rx_data, b;
  logic [15:0] baud_div, baud_div_now, cur_div, lfsr;
  logic rx_frame_err, rx_overrun, h4_type_err, wake_enable, wake_polarity;
  logic device_wake_request, device_awake, host_wake_request, host_wake_polarity, host_wake;
  logic hold_off, ignore_rts, host_rx, host_cts_n;
  logic [2:0] tx_sel;
  // Rate table with both clamp ends, and host periods a few percent off the 921600 setting
  logic [15:0] rates[5] = '{DIV_COMMON_A, DIV_COMMON_B, 16'h0005, 16'h0400, DIV_MIN};
  int skews[2] = '{113, 105};
  logic [8:0] got;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int tests_run = 0;
  int fe_cnt = 0;
  int ov_cnt = 0;
  int h4_cnt = 0;

  always #5 clk = ~clk;

  // Driven pins show the device, others their pull-up or the host
  always_comb
  begin
    gpio_in = gpio_out | ~gpio_oe;
    gpio_in[RXP] = host_rx;
    gpio_in[CTP] = host_cts_n;
  end

  // One-cycle error pulses are counted so no check can miss them
  always @(posedge clk)
  begin
    fe_cnt <= fe_cnt + int'(rx_frame_err === 1'b1);
    ov_cnt <= ov_cnt + int'(rx_overrun === 1'b1);
    h4_cnt <= h4_cnt + int'(h4_type_err === 1'b1);
  end

  hwu_port #(.FIFO_DEPTH(DEPTH), .N_GPIO(8), .SEL_W(3)) dut (.clk(clk), .rst(rst), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .rx_pin_sel(3'h5), .cts_pin_sel(3'h6), .tx_pin_sel(tx_sel),
    .rts_pin_sel(3'h4), .baud_div(baud_div), .baud_load(baud_load), .baud_div_now(baud_div_now),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .rx_sop(rx_sop), .rx_frame_err(rx_frame_err), .rx_overrun(rx_overrun),
    .h4_type_err(h4_type_err), .wake_enable(wake_enable), .wake_polarity(wake_polarity),
    .device_wake_request(device_wake_request), .device_awake(device_awake),
    .host_wake_request(host_wake_request), .host_wake_polarity(host_wake_polarity), .host_wake(host_wake));

  hwu_host_model host (.clk(clk), .rst(rst), .div(cur_div), .hold_off(hold_off), .ignore_rts(ignore_rts),
    .tx_pin(gpio_in[TXP]), .rts_n(gpio_in[RTP]), .rx_pin(host_rx), .cts_n(host_cts_n));

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Divisor the port should settle on for a requested value
  function automatic logic [15:0] exp_div(input logic [15:0] d);
    if (d < DIV_MIN)
      return DIV_MIN;
    if (d > DIV_MAX)
      return DIV_MAX;
    return d;
  endfunction

  task automatic tally_and_finish;
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] g, input logic [15:0] e, input string what);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e, input string what);
    chk_val({15'h0, g}, {15'h0, e}, what);
  endtask

  task automatic give_up(input string what);
    error_cnt++;
    $display("BAD %0t %s timed out", $time, what);
    tally_and_finish();
  endtask

  task automatic push_tx(input logic [7:0] d);
    int n;
    // A clock edge with valid low separates two pushes
    @(negedge clk);
    for (n = 0; n < 20000 && tx_ready !== 1'b1; n++)
      @(negedge clk);
    if (n == 20000)
      give_up("tx ready");
    tx_valid = 1'b1;
    tx_data = d;
    @(negedge clk);
    tx_valid = 1'b0;
  endtask

  task automatic pop_rx(input logic sop, output logic [7:0] d);
    int n;
    for (n = 0; n < 20000; n++)
    begin
      @(negedge clk);
      if (rx_valid === 1'b1)
        break;
    end
    if (n == 20000)
      give_up("rx valid");
    d = rx_data;
    rx_sop = sop;
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
    rx_sop = 1'b0;
  endtask

  task automatic host_get(output logic [8:0] g);
    int n;
    for (n = 0; n < 20000 && host.got_q.size() == 0; n++)
      @(negedge clk);
    if (n == 20000)
      give_up("host receive");
    g = host.got_q.pop_front();
  endtask

  task automatic set_div(input logic [15:0] d);
    baud_div = d;
    baud_load = 1'b1;
    @(negedge clk);
    baud_load = 1'b0;
    @(negedge clk);
    cur_div = exp_div(d);
    chk_val(baud_div_now, cur_div, "rate load");
  endtask

  // One byte each way at the current rate; host follows the device rate
  task automatic xfer(input logic [7:0] d);
    push_tx(d);
    host_get(got);
    chk_val({7'h0, got}, {7'h0, 1'b1, d}, "host got");
    host.send(~d, int'(cur_div), 1'b1);
    pop_rx(1'b0, b);
    chk_val({8'h0, b}, {8'h0, ~d}, "device got");
  endtask

  initial
  begin
    {clk, baud_load, tx_valid, rx_ready, rx_sop, wake_enable, device_wake_request} = '0;
    {host_wake_request, hold_off, ignore_rts, tx_data, baud_div} = '0;
    {wake_polarity, host_wake_polarity} = 2'b11;
    tx_sel = 3'(TXP);
    rst = 1'b1;
    lfsr = 16'hefc4;
    cur_div = DIV_DEFAULT;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk_val(baud_div_now, DIV_DEFAULT, "default rate");
    chk_val({8'h0, gpio_oe}, 16'h0012, "driven pins");
    chk_bit(gpio_in[RTP], 1'b0, "rts when empty");
    // Indicator byte out and its complement back at the reset rate
    xfer(8'h01);
    // Rate table, clamping at both ends
    foreach (rates[i])
    begin
      set_div(rates[i]);
      lfsr = lfsr_next(lfsr);
      xfer(lfsr[7:0]);
    end
    // Host clock off by a few percent either way
    set_div(DIV_COMMON_A);
    foreach (skews[i])
    begin
      host.send(8'h3c, skews[i], 1'b1);
      pop_rx(1'b0, b);
      chk_val({8'h0, b}, 16'h003c, "skewed rate");
    end
    set_div(DIV_MIN);
    // Low stop bit drops the byte; next one still lands
    host.send(8'h5a, int'(cur_div), 1'b0);
    repeat (3 * cur_div) @(negedge clk);
    chk_val(16'(fe_cnt), 16'h1, "frame error");
    chk_bit(rx_valid, 1'b0, "dropped byte");
    xfer(8'hc3);
    // Indicator check over the valid span and its neighbours
    for (int v = 0; v < 7; v++)
    begin
      host.send(8'(v), int'(cur_div), 1'b1);
      pop_rx(1'b1, b);
      repeat (3) @(negedge clk);
      chk_val(16'(h4_cnt), 16'(1 + int'(v > 5)), "indicator error");
    end
    // Wake lines: ignored until enabled, then follow both polarities
    device_wake_request = 1'b1;
    host_wake_request = 1'b1;
    repeat (6) @(negedge clk);
    chk_bit(device_awake, 1'b0, "awake while off");
    chk_bit(host_wake, 1'b0, "host wake while off");
    wake_enable = 1'b1;
    for (int p = 0; p < 4; p++)
    begin
      {wake_polarity, host_wake_polarity} = {2{p[0]}};
      {device_wake_request, host_wake_request} = {2{p[1]}};
      repeat (6) @(negedge clk);
      chk_bit(device_awake, p[0] ~^ p[1], "device awake");
      chk_bit(host_wake, p[1] ? p[0] : !p[0], "host wake");
    end
    host_wake_request = 1'b0;
    // CTS high: queued byte waits, host is woken for it
    hold_off = 1'b1;
    repeat (4) @(negedge clk);
    push_tx(8'ha5);
    repeat (15 * cur_div) @(negedge clk);
    chk_val(16'(host.got_q.size()), 16'h0, "sent under cts");
    chk_bit(host_wake, 1'b1, "wake for pending tx");
    hold_off = 1'b0;
    host_get(got);
    chk_val({7'h0, got}, 16'h01a5, "held byte");
    // Back-to-back bytes leave in order
    for (int i = 0; i < 5; i++)
    begin
      lfsr = lfsr_next(lfsr);
      exp_q.push_back(lfsr[7:0]);
      push_tx(lfsr[7:0]);
    end
    foreach (exp_q[i])
    begin
      host_get(got);
      chk_val({7'h0, got}, {7'h0, 1'b1, exp_q[i]}, "burst byte");
    end
    // Fill receive FIFO past the flow threshold, then overrun
    ignore_rts = 1'b1;
    for (int i = 0; i <= DEPTH; i++)
    begin
      host.send(8'(i), int'(cur_div), 1'b1);
      repeat (4) @(negedge clk);
      chk_bit(gpio_in[RTP], i + 1 >= DEPTH - RTS_MARGIN, "rts level");
    end
    chk_val(16'(ov_cnt), 16'h1, "overrun");
    ignore_rts = 1'b0;
    for (int i = 0; i < DEPTH; i++)
    begin
      pop_rx(1'b0, b);
      chk_val({8'h0, b}, 16'(i), "drained byte");
    end
    repeat (4) @(negedge clk);
    chk_bit(gpio_in[RTP], 1'b0, "rts after drain");
    chk_bit(rx_valid, 1'b0, "fifo empty");
    // Transmit output follows its pin select while the line is idle
    tx_sel = 3'h2;
    repeat (3) @(negedge clk);
    chk_val({8'h0, gpio_oe}, 16'h0014, "moved tx pin");
    chk_bit(gpio_out[2], 1'b1, "idle tx level");
    tally_and_finish();
  end
endmodule
